// file: decode_pkg.sv
package decode_pkg;

    // Phase of the instruction cycle, one oscillator period each
    typedef enum logic [1:0] {
        PH_FETCH = 2'h0,
        PH_DECODE = 2'h1,
        PH_EXEC = 2'h2,
        PH_WRITE = 2'h3
    } phase_t;

    typedef enum logic [1:0] {
        FMT_BYTE = 2'h0,
        FMT_BIT = 2'h1,
        FMT_JUMP = 2'h2,
        FMT_LIT = 2'h3
    } fmt_t;

    // Views of one 14-bit instruction word
    typedef struct packed {
        fmt_t fmt;
        logic [3:0] op;
        logic d;
        logic [6:0] f;
    } byte_word_t;

    typedef struct packed {
        fmt_t fmt;
        logic [1:0] op;
        logic [2:0] b;
        logic [6:0] f;
    } bit_word_t;

    typedef struct packed {
        fmt_t fmt;
        logic [3:0] op;
        logic [7:0] k;
    } lit_word_t;

    typedef struct packed {
        fmt_t fmt;
        logic is_goto;
        logic [10:0] k;
    } jump_word_t;

    // Low byte of the control group with op = 0 and d = 0
    localparam logic [7:0] CTL_RETURN = 8'h08;
    localparam logic [7:0] CTL_RETFIE = 8'h09;
    localparam logic [7:0] CTL_SLEEP = 8'h63;
    localparam logic [7:0] CTL_CLRWDT = 8'h64;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CORE = 8'h04;
    localparam logic [7:0] OFS_PC = 8'h08;

    localparam logic [7:0] RST_W = 8'h00;
    localparam logic [10:0] RST_PC = 11'h000;
    localparam logic RST_TO = 1'b1;
    localparam logic RST_PD = 1'b1;
    localparam logic RST_RUN = 1'b1;

    typedef struct packed {
        logic [18:0] zero;
        logic to;
        logic pd;
        logic z;
        logic dc;
        logic c;
        logic [7:0] w;
    } core_view_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } rf_req_t;

endpackage

// file: fourteen_bit_instruction_decode.sv
// Behaviour
// - Take each instruction as one 14-bit word split into opcode and operands.
// - Tell byte, bit and literal/control formats apart, each with its field layout.
// - Byte ops: d = 0 sends result to accumulator, d = 1 to the register.
// - Register address selects one of registers 0x00 to 0x7F.
// - Bit ops affect only the selected bit of the 8-bit register.
// - Literal is 8 bits, but 11 bits for call and jump.
// - One instruction cycle is four consecutive clock periods.
// - One cycle, or two with a no-op second when skipping or branching.
// - Register operands are read, modified, then stored per opcode or d.
// - The register is read even when the instruction only writes it.
// - Don't-care opcode bits are ignored; either value decodes the same.
// - Bit format holds a 3-bit bit select between opcode and 7-bit address.
// - Watchdog-clear encoding recognised; sets timeout and power-down status bits.
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module fourteen_bit_instruction_decode (
    input wire logic clk_in, // 50 MHz core clock
    input wire logic rst_n_in, // Synchronous reset, active low
    input wire logic ce_in, // Clock enable, freezes all state when low
    input wire decode_pkg::apb_req_t apb_in, // APB request
    output decode_pkg::apb_rsp_t apb_out, // APB response
    output logic [10:0] pc_out, // Program memory address
    input wire logic [13:0] instr_in, // Instruction word at pc_out
    output decode_pkg::rf_req_t rf_out, // Register file read and write
    input wire logic [7:0] rd_data_in, // Register file read data
    input wire logic [10:0] ret_addr_in, // Top of return stack
    output logic push_out, // Push pc + 1 onto return stack
    output logic pop_out, // Pop return stack
    output logic wdt_clr_out, // Clear watchdog
    output logic sleep_out, // Enter sleep
    output logic timeout_flag_out, // Timeout status bit
    output logic sleep_entered_flag_out, // Power-down status bit
    output logic nibble_carry_flag_out, // Digit carry
    output logic [7:0] accum_out // Accumulator
);
    import decode_pkg::*;

    typedef struct packed {
        phase_t q;
        logic [13:0] ir;
        logic flush;
        logic bubble;
        logic [10:0] pc;
        logic [7:0] w;
        logic z;
        logic c;
        logic dc;
        logic to;
        logic pd;
        logic run;
        logic push;
        logic pop;
        logic wdt_clr;
        logic sleep;
        rf_req_t rf;
        apb_rsp_t apb;
    } state_t;

    state_t st;
    state_t next_st;

    byte_word_t bw;
    bit_word_t btw;
    lit_word_t lw;
    jump_word_t jw;
    assign bw = st.ir;
    assign btw = st.ir;
    assign lw = st.ir;
    assign jw = st.ir;

    logic [7:0] a;
    logic [7:0] res;
    logic [7:0] mask;
    logic [9:0] sum;
    logic wr_f;
    logic wr_w;
    logic skip;
    logic need_rd;
    logic upd_z;
    logic upd_c;
    logic upd_dc;
    logic new_c;
    logic ret;
    logic slp;
    logic wdt;
    core_view_t view;

    // Returns {carry, nibble carry, sum}
    function automatic logic [9:0] add8(input logic [7:0] x, input logic [7:0] y, input logic ci);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        hi = {1'b0, x[7:4]} + {1'b0, y[7:4]} + {4'h0, lo[4]};
        return {hi[4], lo[4], hi[3:0], lo[3:0]};
    endfunction

    assign a = rd_data_in;

    always_comb begin
        next_st = st;
        res = 8'h00;
        sum = 10'h000;
        wr_f = 1'b0;
        wr_w = 1'b0;
        skip = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        upd_dc = 1'b0;
        new_c = 1'b0;
        ret = 1'b0;
        slp = 1'b0;
        wdt = 1'b0;
        mask = 8'h01 << btw.b;
        view = '0;
        // Every register operand is read, write-only ones too
        need_rd = (bw.fmt == FMT_BIT) || (bw.fmt == FMT_BYTE && (bw.d || bw.op[3:1] != 3'h0));
        unique case (bw.fmt)
            FMT_BYTE: begin
                unique case (bw.op)
                    4'h0: begin
                        res = st.w;
                        if (!bw.d) begin
                            // Control group; bits 6:5 of a no-op are ignored
                            unique casez (st.ir[7:0])
                                CTL_RETURN, CTL_RETFIE: ret = 1'b1;
                                CTL_SLEEP: slp = 1'b1;
                                CTL_CLRWDT: wdt = 1'b1;
                                default: ;
                            endcase
                        end
                    end
                    4'h1: begin
                        res = 8'h00;
                        upd_z = 1'b1;
                    end
                    4'h2: begin
                        sum = add8(a, ~st.w, 1'b1);
                        upd_c = 1'b1;
                        upd_dc = 1'b1;
                    end
                    4'h3: res = a - 8'h01;
                    4'h4: res = a | st.w;
                    4'h5: res = a & st.w;
                    4'h6: res = a ^ st.w;
                    4'h7: begin
                        sum = add8(a, st.w, 1'b0);
                        upd_c = 1'b1;
                        upd_dc = 1'b1;
                    end
                    4'h8: res = a;
                    4'h9: res = ~a;
                    4'ha: res = a + 8'h01;
                    4'hb: begin
                        res = a - 8'h01;
                        skip = (res == 8'h00);
                    end
                    4'hc: begin
                        res = {st.c, a[7:1]};
                        new_c = a[0];
                    end
                    4'hd: begin
                        res = {a[6:0], st.c};
                        new_c = a[7];
                    end
                    4'he: res = {a[3:0], a[7:4]};
                    4'hf: begin
                        res = a + 8'h01;
                        skip = (res == 8'h00);
                    end
                endcase
                if (upd_c) begin
                    res = sum[7:0];
                    new_c = sum[9];
                end
                upd_z = upd_z || !(bw.op inside {4'h0, 4'hb, 4'hc, 4'hd, 4'he, 4'hf});
                upd_c = upd_c || bw.op == 4'hc || bw.op == 4'hd;
                // Result goes to the register for d = 1, else to the accumulator
                wr_f = bw.d;
                wr_w = !bw.d && bw.op != 4'h0;
            end
            FMT_BIT: begin
                unique case (btw.op)
                    2'h0: begin
                        res = a & ~mask;
                        wr_f = 1'b1;
                    end
                    2'h1: begin
                        res = a | mask;
                        wr_f = 1'b1;
                    end
                    2'h2: skip = ((a & mask) == 8'h00);
                    2'h3: skip = ((a & mask) != 8'h00);
                endcase
            end
            FMT_JUMP: res = st.w;
            FMT_LIT: begin
                wr_w = 1'b1;
                unique casez (lw.op)
                    4'b00??: res = lw.k;
                    4'b01??: begin
                        res = lw.k;
                        ret = 1'b1;
                    end
                    4'b1000: res = lw.k | st.w;
                    4'b1001: res = lw.k & st.w;
                    4'b1010: res = lw.k ^ st.w;
                    4'b110?: begin
                        sum = add8(lw.k, ~st.w, 1'b1);
                        upd_c = 1'b1;
                    end
                    4'b111?: begin
                        sum = add8(lw.k, st.w, 1'b0);
                        upd_c = 1'b1;
                    end
                    default: wr_w = 1'b0;
                endcase
                if (upd_c) begin
                    res = sum[7:0];
                    new_c = sum[9];
                    upd_dc = 1'b1;
                end
                upd_z = wr_w && lw.op[3];
            end
        endcase

        // Instruction cycle of four periods
        if (st.run) begin
            unique case (st.q)
                PH_FETCH: begin
                    next_st.ir = st.flush ? 14'h0000 : instr_in;
                    next_st.bubble = st.flush;
                    next_st.flush = 1'b0;
                    next_st.q = PH_DECODE;
                end
                PH_DECODE: begin
                    next_st.rf.rd = need_rd;
                    next_st.rf.addr = bw.f;
                    next_st.q = PH_EXEC;
                end
                PH_EXEC: begin
                    next_st.rf.rd = 1'b0;
                    next_st.q = PH_WRITE;
                    if (!st.bubble) begin
                        next_st.rf.wr = wr_f;
                        next_st.rf.data = res;
                        if (wr_w) begin
                            next_st.w = res;
                        end
                        if (upd_z) begin
                            next_st.z = (res == 8'h00);
                        end
                        if (upd_c) begin
                            next_st.c = new_c;
                        end
                        if (upd_dc) begin
                            next_st.dc = sum[8];
                        end
                        if (wdt) begin
                            next_st.to = 1'b1;
                            next_st.pd = 1'b1;
                            next_st.wdt_clr = 1'b1;
                        end
                        if (slp) begin
                            next_st.to = 1'b1;
                            next_st.pd = 1'b0;
                            next_st.sleep = 1'b1;
                        end
                        // Skips and branches spend a second cycle as a no-op
                        next_st.pc = st.pc + 11'h001;
                        if (skip) begin
                            next_st.pc = st.pc + 11'h002;
                            next_st.flush = 1'b1;
                        end
                        if (bw.fmt == FMT_JUMP) begin
                            next_st.pc = jw.k;
                            next_st.push = !jw.is_goto;
                            next_st.flush = 1'b1;
                        end
                        if (ret) begin
                            next_st.pc = ret_addr_in;
                            next_st.pop = 1'b1;
                            next_st.flush = 1'b1;
                        end
                    end
                end
                PH_WRITE: begin
                    next_st.rf.wr = 1'b0;
                    next_st.push = 1'b0;
                    next_st.pop = 1'b0;
                    next_st.wdt_clr = 1'b0;
                    next_st.sleep = 1'b0;
                    next_st.q = PH_FETCH;
                end
            endcase
        end

        // APB slave, one wait state
        next_st.apb.pready = 1'b0;
        next_st.apb.pslverr = 1'b0;
        if (apb_in.psel && apb_in.penable && !st.apb.pready) begin
            next_st.apb.pready = 1'b1;
            next_st.apb.prdata = 32'h0000_0000;
            view.w = st.w;
            view.c = st.c;
            view.dc = st.dc;
            view.z = st.z;
            view.pd = st.pd;
            view.to = st.to;
            unique case (apb_in.paddr)
                OFS_CTRL: begin
                    next_st.apb.prdata = {31'h0, st.run};
                    if (apb_in.pwrite) begin
                        next_st.run = apb_in.pwdata[0];
                    end
                end
                OFS_CORE: next_st.apb.prdata = view;
                OFS_PC: next_st.apb.prdata = {21'h0, st.pc};
                default: next_st.apb.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st <= '0;
            st.pc <= RST_PC;
            st.w <= RST_W;
            st.to <= RST_TO;
            st.pd <= RST_PD;
            st.run <= RST_RUN;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    assign apb_out = st.apb;
    assign pc_out = st.pc;
    assign rf_out = st.rf;
    assign push_out = st.push;
    assign pop_out = st.pop;
    assign wdt_clr_out = st.wdt_clr;
    assign sleep_out = st.sleep;
    assign timeout_flag_out = st.to;
    assign sleep_entered_flag_out = st.pd;
    assign nibble_carry_flag_out = st.dc;
    assign accum_out = st.w;

    logic ex;
    assign ex = ce_in && st.run && st.q == PH_EXEC && !st.bubble;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_quad_step: assert property (ce_in && st.run |=> st.q == $past(st.q) + 2'h1)
        else $error("phase did not advance by one");
    chk_read_first: assert property ($rose(st.rf.wr) |-> $past(st.rf.rd))
        else $error("register written without prior read");
    chk_dest_accum: assert property (ex && bw.fmt == FMT_BYTE && !bw.d |=> !st.rf.wr)
        else $error("d=0 result wrote the register");
    chk_dest_file: assert property (ex && bw.fmt == FMT_BYTE && bw.d |=> st.rf.wr ##1 !st.rf.wr)
        else $error("d=1 result not written back once");
    chk_addr_field: assert property ($rose(st.rf.rd) |-> st.rf.addr == st.ir[6:0])
        else $error("register address not taken from word");
    chk_bit_only: assert property ($rose(st.rf.wr) && bw.fmt == FMT_BIT
        |-> ((st.rf.data ^ $past(rd_data_in)) & ~mask) == 8'h00)
        else $error("bit op changed other bits");
    chk_jump_target: assert property (ex && bw.fmt == FMT_JUMP |=> st.pc == $past(st.ir[10:0]) && st.flush)
        else $error("jump target or flush wrong");
    chk_bubble_nop: assert property (ce_in && st.run && st.q == PH_FETCH && st.flush
        |=> st.ir == 14'h0000 && st.bubble)
        else $error("second cycle not a no-op");
    chk_watchdog_clr: assert property (ex && st.ir == {6'h00, CTL_CLRWDT} |=> st.to && st.pd && st.wdt_clr)
        else $error("watchdog clear did not update status");
    chk_literal_load: assert property (ex && lw.fmt == FMT_LIT && lw.op[3:2] == 2'h0 |=> st.w == $past(lw.k))
        else $error("literal not loaded into accumulator");

    cov_goto: cover property (ex && bw.fmt == FMT_JUMP ##[1:8] st.bubble);
    cov_skip: cover property (ex && skip ##1 st.flush);
    cov_rmw_write: cover property ($rose(st.rf.wr) && bw.fmt == FMT_BIT);
    cov_apb_ctrl: cover property (st.apb.pready && apb_in.pwrite && apb_in.paddr == OFS_CTRL);
endmodule

// file: prog_mem.sv
`timescale 1ns/1ps
// Program store seen from the core: same-clock memory, word at the address
module prog_mem (
    input wire logic clk_in, // Core clock
    input wire logic [10:0] addr_in, // Program address
    output logic [13:0] word_out // Instruction word at addr_in
);
    logic [13:0] mem [0:2047];

    // Whole 14-bit words only; the bench fills the array while reset is held
    assign word_out = mem[addr_in];
endmodule

// file: tb_fourteen_bit_instruction_decode.sv
`timescale 1ns/1ps
module tb_fourteen_bit_instruction_decode;
    import decode_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic ce_in = 1'b1;
    apb_req_t apb_req = '0;
    apb_rsp_t apb_rsp;
    logic [10:0] pc_out;
    logic [13:0] instr;
    rf_req_t rf_req;
    logic [7:0] rd_data;
    logic push, pop, wdt_clr, sleep_pulse, tflag, sflag;
    logic [7:0] accum;
    logic dcflag;
    logic [7:0] rf_mem [0:127];
    int rd_cnt, wr_cnt, push_cnt, wdt_cnt, sleep_cnt;
    int num_errors = 0;
    int checks = 0;

    initial begin
        forever #10 clk_in = ~clk_in;
    end

    prog_mem i_mem (.clk_in(clk_in), .addr_in(pc_out), .word_out(instr));

    fourteen_bit_instruction_decode i_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .apb_in(apb_req), .apb_out(apb_rsp),
        .pc_out(pc_out), .instr_in(instr), .rf_out(rf_req), .rd_data_in(rd_data),
        .ret_addr_in(11'h000), .push_out(push), .pop_out(pop), .wdt_clr_out(wdt_clr),
        .sleep_out(sleep_pulse), .timeout_flag_out(tflag), .sleep_entered_flag_out(sflag),
        .nibble_carry_flag_out(dcflag), .accum_out(accum)
    );

    // Register file: data only while read strobe is up, garbage otherwise
    assign rd_data = rf_req.rd ? rf_mem[rf_req.addr] : ~rf_mem[rf_req.addr];

    always @(posedge clk_in) begin
        if (rst_n_in && ce_in) begin
            if (rf_req.wr) rf_mem[rf_req.addr] <= rf_req.data;
            rd_cnt += int'(rf_req.rd);
            wr_cnt += int'(rf_req.wr);
            push_cnt += int'(push);
            wdt_cnt += int'(wdt_clr);
            sleep_cnt += int'(sleep_pulse);
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                            output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge clk_in);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 20);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
        // One idle edge so the next setup never overwrites this release
        @(posedge clk_in);
        if (n >= 20) begin
            num_errors++;
            conclude();
        end
    endtask

    task automatic hold_reset();
        rst_n_in <= 1'b0;
        for (int i = 0; i < 2048; i++) i_mem.mem[i] = 14'h0000;
        repeat (3) @(posedge clk_in);
    endtask

    task automatic release_reset();
        rst_n_in <= 1'b1;
        rd_cnt = 0;
        wr_cnt = 0;
        push_cnt = 0;
        wdt_cnt = 0;
        sleep_cnt = 0;
        @(posedge clk_in);
    endtask

    // Waits for pc_out to take value v, then counts the cycles it stands
    task automatic pc_stay(input logic [10:0] v, output logic [31:0] n);
        int w;
        w = 0;
        n = 0;
        while (pc_out !== v && w < 200) begin
            @(posedge clk_in);
            w++;
        end
        while (pc_out === v && n < 200) begin
            @(posedge clk_in);
            n++;
        end
        if (w >= 200) begin
            num_errors++;
            conclude();
        end
    endtask

    task automatic test_byte_ops();
        hold_reset();
        rf_mem[8'h10] = 8'h11;
        rf_mem[8'h11] = 8'h01;
        rf_mem[8'h05] = 8'h33;
        i_mem.mem[0] = 14'h335a;
        i_mem.mem[1] = 14'h00ff;
        i_mem.mem[2] = 14'h0185;
        i_mem.mem[3] = 14'h0710;
        i_mem.mem[4] = 14'h0791;
        release_reset();
        check("accum at reset", 32'h0, {24'h0, accum});
        repeat (24) @(posedge clk_in);
        check("reg 7f", 32'h5a, {24'h0, rf_mem[8'h7f]});
        check("cleared reg", 32'h0, {24'h0, rf_mem[8'h05]});
        check("accum", 32'h6b, {24'h0, accum});
        check("reg 11", 32'h6c, {24'h0, rf_mem[8'h11]});
        check("nibble carry", 32'h0, {31'h0, dcflag});
        check("reads", 32'd4, rd_cnt);
        check("writes", 32'd3, wr_cnt);
        $display("test byte_ops done");
    endtask

    task automatic test_bit_ops();
        hold_reset();
        rf_mem[8'h20] = 8'h00;
        rf_mem[8'h21] = 8'hff;
        i_mem.mem[0] = 14'h15a0;
        i_mem.mem[1] = 14'h13a1;
        release_reset();
        repeat (12) @(posedge clk_in);
        check("bit set", 32'h08, {24'h0, rf_mem[8'h20]});
        check("bit clear", 32'h7f, {24'h0, rf_mem[8'h21]});
        $display("test bit_ops done");
    endtask

    task automatic test_flow();
        logic [31:0] n;
        hold_reset();
        rf_mem[8'h22] = 8'h01;
        i_mem.mem[0] = 14'h1c22;
        i_mem.mem[1] = 14'h3eff;
        i_mem.mem[2] = 14'h2955;
        i_mem.mem[11'h155] = 14'h2040;
        i_mem.mem[11'h41] = 14'h1822;
        release_reset();
        pc_stay(11'h002, n);
        check("skip cycles", 32'd8, n);
        pc_stay(11'h155, n);
        check("jump cycles", 32'd8, n);
        pc_stay(11'h040, n);
        check("call cycles", 32'd8, n);
        pc_stay(11'h041, n);
        check("plain cycles", 32'd4, n);
        pc_stay(11'h042, n);
        check("no skip cycles", 32'd4, n);
        check("skipped word", 32'h0, {24'h0, accum});
        check("pushes", 32'd1, push_cnt);
        $display("test flow done");
    endtask

    task automatic test_status();
        logic [31:0] n;
        hold_reset();
        i_mem.mem[0] = 14'h0063;
        i_mem.mem[1] = 14'h0064;
        i_mem.mem[2] = 14'h0060;
        release_reset();
        check("flags at reset", 32'h3, {30'h0, tflag, sflag});
        // Sleep executes at the third edge; look before the watchdog clear runs
        repeat (3) @(posedge clk_in);
        check("flags after sleep", 32'h2, {30'h0, tflag, sflag});
        pc_stay(11'h002, n);
        check("flags after clear", 32'h3, {30'h0, tflag, sflag});
        check("nop x bits", 32'd4, n);
        check("watchdog pulses", 32'd1, wdt_cnt);
        check("sleep pulses", 32'd1, sleep_cnt);
        $display("test status done");
    endtask

    task automatic test_regs();
        logic [31:0] rd, pc0;
        logic err;
        apb_xfer(1'b0, 8'h04, 32'h0, rd, err);
        check("core view", 32'h1800, rd & 32'h18ff);
        apb_xfer(1'b0, 8'h0c, 32'h0, rd, err);
        check("unmapped err", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        apb_xfer(1'b1, 8'h00, 32'h0, rd, err);
        apb_xfer(1'b0, 8'h08, 32'h0, pc0, err);
        apb_xfer(1'b1, 8'h08, 32'h7ff, rd, err);
        check("ro write err", 32'h0, {31'h0, err});
        repeat (10) @(posedge clk_in);
        apb_xfer(1'b0, 8'h08, 32'h0, rd, err);
        check("halted pc", pc0, rd);
        apb_xfer(1'b0, 8'h00, 32'h0, rd, err);
        check("ctrl", 32'h0, rd & 32'h1);
        apb_xfer(1'b1, 8'h00, 32'h1, rd, err);
        // Twelve running edges before the pc is sampled: exactly three cycles
        repeat (9) @(posedge clk_in);
        apb_xfer(1'b0, 8'h08, 32'h0, rd, err);
        check("running pc", pc0 + 32'd3, rd);
        $display("test regs done");
    endtask

    initial begin
        repeat (3) @(posedge clk_in);
        test_byte_ops();
        test_bit_ops();
        test_flow();
        test_status();
        test_regs();
        conclude();
    end
endmodule
